// file: logic/ncr_config_regs.sv
// Configuration register space of the network controller.
// Assumes a same-clock register master and a same-clock serial memory loader.
//
// How it works
// - Hardware reset restores every default value
// - Software reset leaves configuration contents untouched
// - Byte, word and dword writes honour lanes
// - Offset zero: device and vendor identifiers
// - Offset four: status high, command low
// - Offset eight: class, subclass, revision
// - Offset 2c: subsystem and subsystem vendor
// - Offset 30: boot ROM base, 128 KB
// - Offset 40: scratch low half, upper reserved
// - Offset c0: caps, next pointer, identifier
// - Offset c4: control/status low, upper reserved
// - Reload identifiers, latency, grant after reset
// - Offset 80: fixed read-only marker word
// - Scratch bits 15..8 read and write
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

module ncr_config_regs #(
  parameter logic [15:0] DEF_DEV_ID   = 16'h0001,      // Arbitrary until loaded
  parameter logic [15:0] DEF_VEN_ID   = 16'h0001,      // Arbitrary until loaded
  parameter logic [15:0] DEF_SUB_ID   = 16'h0000,
  parameter logic [15:0] DEF_SUB_VEN  = 16'h0000,
  parameter logic [7:0]  BASE_CLASS   = 8'h02,
  parameter logic [7:0]  SUB_CLASS    = 8'h00,
  parameter logic [7:0]  REV_STEP     = 8'h10,         // Arbitrary revision/step
  parameter logic [31:0] MARKER_VALUE = 32'h1234_5678, // Arbitrary marker value
  parameter logic [15:0] PM_CAPS_VAL  = 16'h0002
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic        SOFT_RST,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  BYTE_EN,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output logic      [31:0] RDATA,
  // Serial memory loader
  output logic             EE_RELOAD_REQ,
  input  wire logic        LOAD_VALID,
  input  wire logic [15:0] LOAD_DEV_ID,
  input  wire logic [15:0] LOAD_VEN_ID,
  input  wire logic [15:0] LOAD_SUB_ID,
  input  wire logic [15:0] LOAD_SUB_VEN,
  input  wire logic [7:0]  LOAD_MAX_LAT,
  input  wire logic [7:0]  LOAD_MIN_GNT,
  // Events from the bus engine
  input  wire logic        NEW_CAP_EN,
  input  wire logic        EVT_PAR_ERR,
  input  wire logic        EVT_SYS_ERR,
  input  wire logic        EVT_MST_ABORT,
  input  wire logic        EVT_TGT_ABORT,
  input  wire logic        EVT_DATA_PAR,
  input  wire logic        EVT_WAKE,
  // Configuration outputs
  output logic      [15:0] CMD_WORD,
  output logic      [31:0] IO_BASE,
  output logic      [31:0] MEM_BASE,
  output logic      [31:0] ROM_BASE,
  output logic      [1:0]  POWER_STATE
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Identifier fields are reloaded after every hardware reset
  logic [15:0]        dev_id_ff, nxt_dev_id;     // Loaded device identifier
  logic [15:0]        ven_id_ff, nxt_ven_id;     // Loaded vendor identifier
  logic [15:0]        cmd_ff, nxt_cmd;           // Command half-word
  logic [15:0]        stat_ff, nxt_stat;         // Sticky status bits only
  logic [15:0]        lat_ff, nxt_lat;           // Latency timer and cache line
  logic [31:0]        io_ff, nxt_io;             // I/O window base
  logic [31:0]        mem_ff, nxt_mem;           // Memory window base
  logic [15:0]        sub_id_ff, nxt_sub_id;     // Subsystem identifier
  logic [15:0]        sub_ven_ff, nxt_sub_ven;   // Subsystem vendor
  logic [31:0]        rom_ff, nxt_rom;           // ROM window base and enable
  logic [7:0]         max_lat_ff, nxt_max_lat;   // Loaded max latency
  logic [7:0]         min_gnt_ff, nxt_min_gnt;   // Loaded min grant
  logic [7:0]         int_line_ff, nxt_int_line; // Interrupt line
  logic [15:0]        scratch_ff, nxt_scratch;   // Driver scratch half-word
  logic [15:0]        power_ctrl_stat_ff, nxt_power_ctrl_stat;       // Power control and status
  ncr_pkg::ncr_load_t ld_ff, nxt_ld;             // Loader sequencing
  logic [31:0]        rdata_ff, nxt_rdata;       // Read answer register

  // Combinational helpers, settled every cycle
  logic [31:0]        lane_mask;                 // Byte lanes of this write
  logic [31:0]        rd_word;                   // Selected word for reads
  logic [31:0]        ev_mask;                   // Status bits set this cycle

  // Masked merge keeps unwritten lanes and read-only bits as they were
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // Decode on the word address; the low two address bits are ignored
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Word mux; anything not listed reads as zero
  // Reads have no side effects; sticky bits clear only on a write
  always_comb begin
    case ({ADDR[7:2], 2'b00})
      ncr_pkg::OFF_ID_PAIR:    rd_word = {dev_id_ff, ven_id_ff};
      ncr_pkg::OFF_CMD_STATUS: begin
        rd_word = {stat_ff | ncr_pkg::STAT_FIXED, cmd_ff};
        rd_word[16 + ncr_pkg::STAT_NEWCAP_BIT] = NEW_CAP_EN;
      end
      ncr_pkg::OFF_CLASS_REV:  rd_word = {BASE_CLASS, SUB_CLASS, 8'h00, REV_STEP};
      ncr_pkg::OFF_LATENCY:    rd_word = {16'h0000, lat_ff};
      ncr_pkg::OFF_IO_BASE:    rd_word = io_ff | ncr_pkg::IO_FIXED;
      ncr_pkg::OFF_MEM_BASE:   rd_word = mem_ff;
      ncr_pkg::OFF_SUBSYS:     rd_word = {sub_id_ff, sub_ven_ff};
      ncr_pkg::OFF_ROM_BASE:   rd_word = rom_ff;
      ncr_pkg::OFF_CAP_PTR:    rd_word = {24'h00_0000, ncr_pkg::CAP_LIST_HEAD};
      ncr_pkg::OFF_INTR_SETUP: begin
        rd_word = {max_lat_ff, min_gnt_ff, ncr_pkg::INTR_PIN_VAL, int_line_ff};
      end
      ncr_pkg::OFF_SCRATCH:    rd_word = {16'h0000, scratch_ff};
      ncr_pkg::OFF_MARKER:     rd_word = MARKER_VALUE;
      ncr_pkg::OFF_PM_CAPS: begin
        rd_word = {PM_CAPS_VAL, ncr_pkg::PM_NEXT_ITEM, ncr_pkg::PM_CAP_ID};
      end
      ncr_pkg::OFF_PM_CTRL:    rd_word = {16'h0000, power_ctrl_stat_ff};
      default:                 rd_word = ncr_pkg::RST_WORD;
    endcase
  end

  // ****************************************************************
  // Next-state logic for all registers
  // ****************************************************************
  // One process keeps set-versus-clear priority visible in one place
  always_comb begin
    lane_mask    = {{8{BYTE_EN[3]}}, {8{BYTE_EN[2]}}, {8{BYTE_EN[1]}}, {8{BYTE_EN[0]}}};
    nxt_dev_id   = dev_id_ff;
    nxt_ven_id   = ven_id_ff;
    nxt_cmd      = cmd_ff;
    nxt_stat     = stat_ff;
    nxt_lat      = lat_ff;
    nxt_io       = io_ff;
    nxt_mem      = mem_ff;
    nxt_sub_id   = sub_id_ff;
    nxt_sub_ven  = sub_ven_ff;
    nxt_rom      = rom_ff;
    nxt_max_lat  = max_lat_ff;
    nxt_min_gnt  = min_gnt_ff;
    nxt_int_line = int_line_ff;
    nxt_scratch  = scratch_ff;
    nxt_power_ctrl_stat    = power_ctrl_stat_ff;
    nxt_ld       = ld_ff;
    nxt_rdata    = ncr_pkg::RST_WORD;
    // Event pulses placed on their status and wake bit positions
    ev_mask      = {EVT_PAR_ERR, EVT_SYS_ERR, EVT_MST_ABORT, EVT_TGT_ABORT, 3'b000,
                    EVT_DATA_PAR, 8'h00, EVT_WAKE, 15'h0000};

    // Read data stand only in the cycle after the strobe
    if (RD_STB) begin
      nxt_rdata = rd_word;
    end

    // Writes; undecoded offsets and read-only words fall through untouched
    if (WR_STB) begin
      if (hit(ADDR, ncr_pkg::OFF_CMD_STATUS)) begin
        nxt_cmd  = 16'(merge({16'h0000, cmd_ff}, WDATA,
                             lane_mask & {16'h0000, ncr_pkg::CMD_WR_MASK}));
        // Writing one clears a sticky status bit
        nxt_stat = stat_ff & ~(WDATA[31:16] & lane_mask[31:16] & ncr_pkg::STAT_W1C_MASK);
      end
      // Latency word: both low bytes writable
      if (hit(ADDR, ncr_pkg::OFF_LATENCY)) begin
        nxt_lat = lat_ff & ~lane_mask[15:0] | WDATA[15:0] & lane_mask[15:0];
      end
      // I/O base: bits 31..8 only, bit 0 is fixed
      if (hit(ADDR, ncr_pkg::OFF_IO_BASE)) begin
        nxt_io = merge(io_ff, WDATA, lane_mask & ncr_pkg::IO_WR_MASK);
      end
      // Memory base: bits 31..8 only
      if (hit(ADDR, ncr_pkg::OFF_MEM_BASE)) begin
        nxt_mem = merge(mem_ff, WDATA, lane_mask & ncr_pkg::MEM_WR_MASK);
      end
      // ROM base: 128 KB aligned, bit 0 enables the window
      if (hit(ADDR, ncr_pkg::OFF_ROM_BASE)) begin
        nxt_rom = merge(rom_ff, WDATA, lane_mask & ncr_pkg::ROM_WR_MASK);
      end
      // Only the interrupt line is writable; pin, grant and latency are not
      if (hit(ADDR, ncr_pkg::OFF_INTR_SETUP) && BYTE_EN[0]) begin
        nxt_int_line = WDATA[7:0];
      end
      // Scratch: only the high byte of the low half keeps data
      if (hit(ADDR, ncr_pkg::OFF_SCRATCH)) begin
        nxt_scratch = scratch_ff & ~(lane_mask[15:0] & ncr_pkg::SCRATCH_WR_MASK)
                    | WDATA[15:0] & lane_mask[15:0] & ncr_pkg::SCRATCH_WR_MASK;
      end
      // Power control: state and wake enable, then wake status clear
      if (hit(ADDR, ncr_pkg::OFF_PM_CTRL)) begin
        nxt_power_ctrl_stat = power_ctrl_stat_ff & ~(lane_mask[15:0] & ncr_pkg::POWER_CTRL_STAT_WR_MASK)
                  | WDATA[15:0] & lane_mask[15:0] & ncr_pkg::POWER_CTRL_STAT_WR_MASK;
        nxt_power_ctrl_stat = nxt_power_ctrl_stat & ~(WDATA[15:0] & lane_mask[15:0] & ncr_pkg::POWER_CTRL_STAT_W1C_MASK);
      end
    end

    // Events set after clears so a same-cycle event is never lost
    nxt_stat  = nxt_stat | ev_mask[31:16];
    nxt_power_ctrl_stat = nxt_power_ctrl_stat | ev_mask[15:0];

    // Loader: ask once after reset, accept one loaded record
    // A pulse before the request or after the first load is dropped
    case (ld_ff)
      ncr_pkg::LD_REQ:  nxt_ld = ncr_pkg::LD_WAIT;
      ncr_pkg::LD_WAIT: begin
        if (LOAD_VALID) begin
          nxt_dev_id  = LOAD_DEV_ID;
          nxt_ven_id  = LOAD_VEN_ID;
          nxt_sub_id  = LOAD_SUB_ID;
          nxt_sub_ven = LOAD_SUB_VEN;
          nxt_max_lat = LOAD_MAX_LAT;
          nxt_min_gnt = LOAD_MIN_GNT;
          nxt_ld      = ncr_pkg::LD_DONE;
        end
      end
      ncr_pkg::LD_DONE: nxt_ld = ncr_pkg::LD_DONE;
      default:          nxt_ld = ncr_pkg::LD_REQ;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Only the hardware reset restores defaults; the software reset has
  // no path in here, so the driver's settings survive it
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      dev_id_ff   <= DEF_DEV_ID;
      ven_id_ff   <= DEF_VEN_ID;
      cmd_ff      <= ncr_pkg::RST_CMD;
      stat_ff     <= ncr_pkg::RST_STAT;
      lat_ff      <= ncr_pkg::RST_HALF;
      io_ff       <= ncr_pkg::RST_WORD;
      mem_ff      <= ncr_pkg::RST_WORD;
      sub_id_ff   <= DEF_SUB_ID;
      sub_ven_ff  <= DEF_SUB_VEN;
      rom_ff      <= ncr_pkg::RST_WORD;
      max_lat_ff  <= ncr_pkg::RST_BYTE;
      min_gnt_ff  <= ncr_pkg::RST_BYTE;
      int_line_ff <= ncr_pkg::RST_BYTE;
      scratch_ff  <= ncr_pkg::RST_HALF;
      power_ctrl_stat_ff    <= ncr_pkg::RST_HALF;
      ld_ff       <= ncr_pkg::LD_REQ;
      rdata_ff    <= ncr_pkg::RST_WORD;
    end else begin
      dev_id_ff   <= nxt_dev_id;
      ven_id_ff   <= nxt_ven_id;
      cmd_ff      <= nxt_cmd;
      stat_ff     <= nxt_stat;
      lat_ff      <= nxt_lat;
      io_ff       <= nxt_io;
      mem_ff      <= nxt_mem;
      sub_id_ff   <= nxt_sub_id;
      sub_ven_ff  <= nxt_sub_ven;
      rom_ff      <= nxt_rom;
      max_lat_ff  <= nxt_max_lat;
      min_gnt_ff  <= nxt_min_gnt;
      int_line_ff <= nxt_int_line;
      scratch_ff  <= nxt_scratch;
      power_ctrl_stat_ff    <= nxt_power_ctrl_stat;
      ld_ff       <= nxt_ld;
      rdata_ff    <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Data outputs come from flip-flops; the reload request decodes state
  assign RDATA         = rdata_ff;
  assign EE_RELOAD_REQ = (ld_ff == ncr_pkg::LD_REQ) && !SRST;  // One cycle after release
  assign CMD_WORD      = cmd_ff;
  assign IO_BASE       = io_ff | ncr_pkg::IO_FIXED;
  assign MEM_BASE      = mem_ff;
  assign ROM_BASE      = rom_ff;
  assign POWER_STATE   = power_ctrl_stat_ff[1:0];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Helper: write data of the previous cycle, for checks after a write
  logic [31:0] wdata_prev_ff;
  always_ff @(posedge CLK_SYS) begin
    wdata_prev_ff <= WDATA;
  end

  chk_reset_defaults: assert property (@(posedge CLK_SYS)
    SRST |=> (cmd_ff == 16'h0000 && scratch_ff == 16'h0000 && rom_ff == 32'h0000_0000))
    else $error("Defaults not restored by hardware reset");

  chk_soft_keep: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (SOFT_RST && !WR_STB) |=> ($stable(scratch_ff) && $stable(lat_ff) && $stable(cmd_ff)))
    else $error("Software reset altered configuration");

  chk_lane_keep: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (WR_STB && hit(ADDR, 8'h40) && !BYTE_EN[1]) |=> $stable(scratch_ff))
    else $error("Unselected byte lane was written");

  chk_id_word: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (RD_STB && ADDR == 8'h00) |=> (RDATA == {$past(dev_id_ff), $past(ven_id_ff)}))
    else $error("Identifier word wrong");

  chk_status_cmd: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (RD_STB && ADDR == 8'h04) |=>
      (RDATA[15:0] == $past(cmd_ff) && RDATA[26:25] == 2'b01 && RDATA[23] == 1'b1 &&
       RDATA[20] == $past(NEW_CAP_EN)))
    else $error("Command or status word wrong");

  chk_class_word: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (RD_STB && ADDR == 8'h08) |=> (RDATA == {BASE_CLASS, SUB_CLASS, 8'h00, REV_STEP}))
    else $error("Class word wrong");

  chk_subsys_word: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (RD_STB && ADDR == 8'h2c) |=> (RDATA == {$past(sub_id_ff), $past(sub_ven_ff)}))
    else $error("Subsystem word wrong");

  chk_rom_window: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (WR_STB && ADDR == 8'h30 && BYTE_EN == 4'hf) |=> (rom_ff == (wdata_prev_ff & 32'hfffe_0001)))
    else $error("ROM base not aligned to 128 KB");

  chk_pm_caps: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (RD_STB && ADDR == 8'hc0) |=> (RDATA == {PM_CAPS_VAL, 8'h00, 8'h01}))
    else $error("Power capability word wrong");

  chk_pm_upper: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (RD_STB && ADDR == 8'hc4) |=> (RDATA[31:16] == 16'h0000))
    else $error("Power control upper half not zero");

  chk_reload_req: assert property (@(posedge CLK_SYS)
    $fell(SRST) |-> (EE_RELOAD_REQ ##1 !EE_RELOAD_REQ))
    else $error("Reload request not one cycle after reset");

  chk_marker_fixed: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (RD_STB && ADDR == 8'h80) |=> (RDATA == MARKER_VALUE))
    else $error("Marker word changed");

  chk_scratch_rw: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (WR_STB && ADDR == 8'h40 && BYTE_EN == 4'hf) |=>
      (scratch_ff == {wdata_prev_ff[15:8], 8'h00}))
    else $error("Scratch bits 15..8 not stored");

  chk_undecoded_zero: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (RD_STB && (ADDR == 8'h18 || ADDR == 8'h38)) |=> (RDATA == 32'h0000_0000))
    else $error("Undecoded offset read not zero");

  chk_cmd_lanes: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (WR_STB && hit(ADDR, 8'h04) && BYTE_EN[1:0] == 2'b00) |=> $stable(cmd_ff))
    else $error("Command changed with its lanes disabled");

  chk_load_once: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (ld_ff == ncr_pkg::LD_DONE) |=> ($stable(dev_id_ff) && $stable(sub_ven_ff)))
    else $error("Identifiers changed after the one load");

  // Cover points for the main scenarios
  cov_reload: cover property (@(posedge CLK_SYS) disable iff (SRST)
    (ld_ff == ncr_pkg::LD_WAIT) && LOAD_VALID);
  cov_set_clear: cover property (@(posedge CLK_SYS) disable iff (SRST)
    WR_STB && ADDR == 8'h04 && WDATA[31] && EVT_PAR_ERR);
  cov_byte_write: cover property (@(posedge CLK_SYS) disable iff (SRST)
    WR_STB && BYTE_EN == 4'h2 ##1 RD_STB);

endmodule

// file: logic/ncr_pkg.sv
// Constants for the configuration register space of the network controller.
// Assumes byte addresses on an 8-bit port, one aligned 32-bit word per register.
package ncr_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_ID_PAIR      = 8'h00;
  localparam logic [7:0] OFF_CMD_STATUS   = 8'h04;
  localparam logic [7:0] OFF_CLASS_REV    = 8'h08;
  localparam logic [7:0] OFF_LATENCY      = 8'h0c;
  localparam logic [7:0] OFF_IO_BASE      = 8'h10;
  localparam logic [7:0] OFF_MEM_BASE     = 8'h14;
  localparam logic [7:0] OFF_SUBSYS       = 8'h2c;
  localparam logic [7:0] OFF_ROM_BASE     = 8'h30;
  localparam logic [7:0] OFF_CAP_PTR      = 8'h34;
  localparam logic [7:0] OFF_INTR_SETUP   = 8'h3c;
  localparam logic [7:0] OFF_SCRATCH      = 8'h40;
  localparam logic [7:0] OFF_MARKER       = 8'h80;
  localparam logic [7:0] OFF_PM_CAPS      = 8'hc0;
  localparam logic [7:0] OFF_PM_CTRL      = 8'hc4;

  // ****************************************************************
  // Writable bit masks and fixed field values
  // ****************************************************************
  localparam logic [15:0] CMD_WR_MASK     = 16'h0157;  // I/O, mem, master, MWI, parity, serr
  localparam logic [15:0] STAT_W1C_MASK   = 16'hf100;  // Sticky error bits 31..28 and 24
  localparam logic [15:0] STAT_FIXED      = 16'h0280;  // Medium select timing, fast b2b
  localparam int          STAT_NEWCAP_BIT = 4;         // Bit 20 of the word
  localparam logic [31:0] IO_WR_MASK      = 32'hffff_ff00;
  localparam logic [31:0] IO_FIXED        = 32'h0000_0001;  // Marks an I/O window
  localparam logic [31:0] MEM_WR_MASK     = 32'hffff_ff00;
  localparam logic [31:0] ROM_WR_MASK     = 32'hfffe_0001;  // 128 KB window plus enable
  localparam logic [7:0]  CAP_LIST_HEAD   = 8'hc0;
  localparam logic [7:0]  INTR_PIN_VAL    = 8'h01;
  localparam logic [15:0] SCRATCH_WR_MASK = 16'hff00;
  localparam logic [7:0]  PM_CAP_ID       = 8'h01;
  localparam logic [7:0]  PM_NEXT_ITEM    = 8'h00;
  localparam logic [15:0] POWER_CTRL_STAT_WR_MASK   = 16'h0103;  // Power state and wake enable
  localparam logic [15:0] POWER_CTRL_STAT_W1C_MASK  = 16'h8000;  // Wake status

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [15:0] RST_CMD         = 16'h0000;
  localparam logic [15:0] RST_STAT        = 16'h0000;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  localparam logic [15:0] RST_HALF        = 16'h0000;

  // ****************************************************************
  // Loader states
  // ****************************************************************
  typedef enum logic [1:0] {
    LD_REQ,
    LD_WAIT,
    LD_DONE
  } ncr_load_t;

endpackage

// file: bench/ncr_loader_model.sv
// Partner model: the serial memory loader that answers the reload request.
// Assumes the register block's clock and an image of six fields handed in by the bench.
`timescale 1ns/1ps

module ncr_loader_model #(
  parameter int DELAY = 8  // Cycles from request to load pulse
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request and load pulse
  input  wire logic        req,
  output logic             valid,
  output logic      [79:0] fields,
  // Image handed over on the pulse
  input  wire logic [79:0] image
);
  // ****************************************************************
  // Loader sequence
  // ****************************************************************
  // Fields toggle every cycle outside the pulse so a stale value never passes
  initial begin
    valid  = 1'b0;
    fields = 80'h0;
    forever begin
      @(posedge clk);
      if (req && !rst) begin
        repeat (DELAY) begin
          @(posedge clk);
          fields <= ~fields;
        end
        valid  <= 1'b1;  // All six fields in one pulse
        fields <= image;
        @(posedge clk);
        valid  <= 1'b0;
        fields <= ~image;
      end else begin
        fields <= ~fields;
      end
    end
  end
endmodule

// file: bench/test_nic_config_space_regs.sv
// Self-checking bench for the configuration register space.
// Assumes the loader model beside it; reads are scored from a queue of expected words.
`timescale 1ns/1ps

module test_nic_config_space_regs;
  // ****************************************************************
  // Stimulus and observation signals
  // ****************************************************************
  logic        clk_sys, srst, soft_rst, wr_stb, rd_stb, rd_d, new_cap_en, ld_valid, reload_req;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, io_base, mem_base, rom_base, r;
  logic [3:0]  byte_en;
  logic [5:0]  evt;       // Wake, then parity, system, master, target, data parity
  logic [79:0] image, fields;
  logic [15:0] cmd_word;
  logic [1:0]  power_state;
  logic [31:0] exp_q[$];  // Expected read words, oldest first
  int          n_errors, checked;

  ncr_config_regs #(.DEF_DEV_ID(16'h0001), .DEF_VEN_ID(16'h0001),
                    .MARKER_VALUE(32'h1234_5678)) uut (
    .CLK_SYS(clk_sys), .SRST(srst), .SOFT_RST(soft_rst), .ADDR(addr), .WDATA(wdata),
    .BYTE_EN(byte_en), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
    .EE_RELOAD_REQ(reload_req), .LOAD_VALID(ld_valid), .LOAD_DEV_ID(fields[79:64]),
    .LOAD_VEN_ID(fields[63:48]), .LOAD_SUB_ID(fields[47:32]), .LOAD_SUB_VEN(fields[31:16]),
    .LOAD_MAX_LAT(fields[15:8]), .LOAD_MIN_GNT(fields[7:0]), .NEW_CAP_EN(new_cap_en),
    .EVT_PAR_ERR(evt[4]), .EVT_SYS_ERR(evt[3]), .EVT_MST_ABORT(evt[2]),
    .EVT_TGT_ABORT(evt[1]), .EVT_DATA_PAR(evt[0]), .EVT_WAKE(evt[5]), .CMD_WORD(cmd_word),
    .IO_BASE(io_base), .MEM_BASE(mem_base), .ROM_BASE(rom_base), .POWER_STATE(power_state));

  ncr_loader_model #(.DELAY(8)) loader (
    .clk(clk_sys), .rst(srst), .req(reload_req), .valid(ld_valid), .fields(fields),
    .image(image));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe beside address, data and lanes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    addr    <= a;
    wdata   <= d;
    byte_en <= be;
    wr_stb  <= 1'b1;
    @(posedge clk_sys);
    wr_stb  <= 1'b0;
  endtask

  // One-cycle read strobe; the word is scored by the monitor a cycle later
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk_sys);
    rd_stb <= 1'b0;
  endtask

  // Hardware reset held two edges; the loader is re-armed by its release
  task automatic hw_reset();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
  endtask

  // Bounded wait for the load pulse, then one edge for it to land
  task automatic wait_load();
    int n;
    n = 0;
    while (ld_valid !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n < 50), 32'h0000_0001);
    @(posedge clk_sys);
  endtask

  task automatic results();
    $display("errors %0d checks %0d pending %0d", n_errors, checked, exp_q.size());
    if (n_errors == 0 && checked > 0 && exp_q.size() == 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Clock, read monitor and watchdog
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    rd_d <= rd_stb;
    if (rd_d === 1'b1) chk(rdata, exp_q.pop_front());
  end

  initial begin
    #(5000 * 50);
    n_errors++;
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {srst, soft_rst, wr_stb, rd_stb, evt, addr, wdata, byte_en} = '0;
    srst       = 1'b1;
    new_cap_en = 1'b1;
    r          = 32'hac0e_566d;
    r          = lfsr(r);
    image      = {r, lfsr(r), 16'(lfsr(lfsr(r)))};  // Fields from the LFSR
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    // Defaults before the loader answers, then the loaded image
    chk({16'h0, cmd_word}, 32'h0000_0000);
    chk(io_base, 32'h0000_0001);
    rd(8'h00, 32'h0001_0001);
    wait_load();
    rd(8'h00, image[79:48]);
    rd(8'h2c, image[47:16]);
    wr(8'h3c, 32'hffff_ffa5, 4'hf);
    rd(8'h3c, {image[15:0], 8'h01, 8'ha5});
    rd(8'h08, 32'h0200_0010);
    rd(8'h34, 32'h0000_00c0);
    rd(8'hc0, 32'h0002_0001);
    rd(8'h80, 32'h1234_5678);
    wr(8'h80, 32'hffff_ffff, 4'hf);
    rd(8'h80, 32'h1234_5678);
    // Scratch lanes: bits 15..8 only, upper half reserved
    wr(8'h40, 32'h0000_ff55, 4'hf);
    rd(8'h40, 32'h0000_ff00);
    wr(8'h40, 32'h1122_3344, 4'b1101);
    rd(8'h40, 32'h0000_ff00);
    wr(8'h40, {16'h0, r[15:0]}, 4'b0010);
    rd(8'h40, {16'h0, r[15:8], 8'h00});
    // Base windows, latency and command with lane limits
    wr(8'h30, 32'hffff_ffff, 4'hf);
    rd(8'h30, 32'hfffe_0001);
    wr(8'h10, 32'hffff_ffff, 4'hf);
    wr(8'h14, 32'hffff_ffff, 4'b0111);
    wr(8'h0c, 32'hffff_ffff, 4'hf);
    rd(8'h0c, 32'h0000_ffff);
    wr(8'h04, 32'hffff_ffff, 4'h3);
    @(posedge clk_sys);
    chk(io_base, 32'hffff_ff01);
    chk(mem_base, 32'h00ff_ff00);
    chk(rom_base, 32'hfffe_0001);
    chk({16'h0, cmd_word}, 32'h0000_0157);
    // Undecoded offsets read zero and keep nothing
    for (int i = 0; i < 6; i++) begin
      wr(8'h18 + 8'(i * 4) + ((i == 5) ? 8'h0c : 8'h00), 32'hffff_ffff, 4'hf);
      rd(8'h18 + 8'(i * 4) + ((i == 5) ? 8'h0c : 8'h00), 32'h0000_0000);
    end
    // Sticky status bits: set by each event, cleared by writing one
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      evt <= 6'h01 << i;
      @(posedge clk_sys);
      evt <= 6'h00;
      rd(8'h04, 32'h0290_0157 | (32'h1 << ((i == 0) ? 24 : 27 + i)));
      wr(8'h04, 32'h1 << ((i == 0) ? 24 : 27 + i), 4'b1000);
      rd(8'h04, 32'h0290_0157);
    end
    // Status bit 20 follows its input live; an event beats a same-cycle clear
    new_cap_en <= 1'b0;
    rd(8'h04, 32'h0280_0157);
    new_cap_en <= 1'b1;
    @(posedge clk_sys);
    addr    <= 8'h04;
    wdata   <= 32'h8000_0000;
    byte_en <= 4'b1000;
    wr_stb  <= 1'b1;
    evt     <= 6'h10;
    @(posedge clk_sys);
    wr_stb  <= 1'b0;
    evt     <= 6'h00;
    rd(8'h04, 32'h8290_0157);
    // Power control: state, wake enable, wake status clear
    wr(8'hc4, 32'hffff_0103, 4'hf);
    @(posedge clk_sys);
    evt <= 6'h20;
    @(posedge clk_sys);
    evt <= 6'h00;
    chk({30'h0, power_state}, 32'h0000_0003);
    rd(8'hc4, 32'h0000_8103);
    wr(8'hc4, 32'h0000_8100, 4'b0010);
    rd(8'hc4, 32'h0000_0103);
    // Software reset keeps contents; hardware reset restores defaults
    @(posedge clk_sys);
    soft_rst <= 1'b1;
    @(posedge clk_sys);
    soft_rst <= 1'b0;
    rd(8'h30, 32'hfffe_0001);
    rd(8'h00, image[79:48]);
    hw_reset();
    rd(8'h00, 32'h0001_0001);
    rd(8'h40, 32'h0000_0000);
    chk({30'h0, power_state}, 32'h0000_0000);
    wait_load();
    rd(8'h04, 32'h0290_0000);
    rd(8'h00, image[79:48]);
    repeat (3) @(posedge clk_sys);
    results();
  end
endmodule
